/* File: rtl/pps_top.sv */
// parallel port pin enables, slave buffers and their status flags
// Contract
// (RQ1) line 14 pad goes to the port when its enable bit is set
// (RQ2) enable bits ten to two hand address pads to the port
// (RQ3) enable bits one and zero hand the two low pads to the port
// (RQ4) chip-select function field picks address bit 14 or chip select one
// (RQ5) mux mode picks low address bits or address latch strobes
// (RQ6) input-all-full reads one only while every input buffer holds data
// (RQ7) host write to a full input buffer sets a sticky overflow flag
// (RQ8) per-buffer input flags set on host write, cleared by software read
// (RQ9) output-all-empty reads one only while every output buffer is empty
// (RQ10) host read of an empty output buffer sets a sticky underflow flag
// (RQ11) per-buffer output-empty flags cleared by software write of data
// (RQ12) buffer flags only meaningful in slave modes
// (RQ13) unimplemented bits read zero and ignore writes
// (RQ14) mode 00 legacy slave, 01 addressable slave, 10/11 master modes
// (RQ15) interrupt mode 10 fires on buffer 3 or address 11 accesses
// (RQ16) chip-select function 10 makes line 14 chip select one
// (RQ17) addressable slave mode selects buffer by the two low address pins
`timescale 1ns/1ps
`default_nettype none
module pps_top
    import pps_pkg::*;
(
    input wire logic sys_clk_i,          // 100 MHz system clock
    input wire logic reset_n_i,          // async reset, active low
    input wire logic wb_cyc_i,           // wishbone cycle
    input wire logic wb_stb_i,           // wishbone strobe
    input wire logic wb_we_i,            // wishbone write enable
    input wire logic [7:0] wb_adr_i,     // wishbone byte address
    input wire logic [3:0] wb_sel_i,     // wishbone byte selects
    input wire logic [31:0] wb_dat_i,    // wishbone write data
    output logic [31:0] wb_dat_o,        // wishbone read data
    output logic wb_ack_o,               // wishbone acknowledge
    input wire logic host_cs_i,          // host chip select, active high
    input wire logic host_rd_i,          // host read strobe, active high
    input wire logic host_wr_i,          // host write strobe, active high
    input wire logic [1:0] host_addr_i,  // host low address pins
    input wire logic [7:0] host_data_i,  // host data bus in
    output logic [7:0] host_data_o,      // host data bus out
    output logic host_data_oe_o,         // host data bus drive enable
    output logic [15:0] pad_port_en_o,   // pads handed to the port
    output logic pad_line14_cs_o,        // line 14 pad is chip select one
    output logic pad_low_latch_o,        // low pads are latch strobes
    output logic irq_o                   // level interrupt
);
    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] cur,
                                                input logic [31:0] wdat,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = cur;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] one_hot(input logic [1:0] idx);
        return 4'h1 << idx;
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] pin_en_reg, pin_en_next;
    logic [31:0] cfg_reg, cfg_next;
    logic [3:0] in_full_reg, in_full_next;
    logic [3:0] out_empty_reg, out_empty_next;
    logic ovf_reg, ovf_next;
    logic unf_reg, unf_next;
    logic [PPS_INT_W-1:0] int_st_reg, int_st_next;
    logic [PPS_INT_W-1:0] int_mask_reg, int_mask_next;
    pps_bus_state_t bus_st_reg, bus_st_next;
    logic [31:0] rdata_reg, rdata_next;
    logic host_rd_prev_reg, host_wr_prev_reg, host_rd_evt_d_reg;
    logic [7:0] host_data_reg;
    logic host_oe_reg;
    logic [15:0] pad_en_reg;
    logic pad_cs_reg, pad_latch_reg, irq_reg;

    pps_mem_if mem_bus ();

    pps_buf_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .bus (mem_bus.mem)
    );

    // ------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------
    wire [1:0] mode = cfg_reg[PPS_CFG_MODE_LSB +: 2];
    wire [1:0] interrupt_request_mode = cfg_reg[PPS_CFG_INTERRUPT_REQUEST_MODE_LSB +: 2];
    wire [1:0] chip_select_function = cfg_reg[PPS_CFG_CSF_LSB +: 2];
    wire [1:0] adr_mux = cfg_reg[PPS_CFG_MUX_LSB +: 2];
    // master modes leave the buffers alone
    wire slave_mode = (mode == PPS_MODE_LEGACY) ||
                      (mode == PPS_MODE_ADDR_SLAVE); // RQ14 RQ12

    // ------------------------------------------------------------------
    // host side strobes
    // ------------------------------------------------------------------
    wire host_rd_lvl = host_cs_i & host_rd_i;
    wire host_wr_lvl = host_cs_i & host_wr_i;
    wire host_rd_evt = host_rd_lvl & ~host_rd_prev_reg & slave_mode;
    wire host_wr_evt = host_wr_lvl & ~host_wr_prev_reg & slave_mode;
    // legacy slave has a single byte, the addressable one four
    wire [1:0] host_idx = (mode == PPS_MODE_ADDR_SLAVE) ? host_addr_i
                          : PPS_BUF_FIRST; // RQ17
    wire [3:0] host_sel = one_hot(host_idx);
    wire host_hits_full = |(host_sel & in_full_reg);
    wire host_hits_empty = |(host_sel & out_empty_reg);
    // full buffers keep their unread byte on overflow
    wire host_store = host_wr_evt & ~host_hits_full;
    wire host_any_evt = host_rd_evt | host_wr_evt;
    wire access_irq = ((interrupt_request_mode == PPS_INTERRUPT_REQUEST_MODE_END) & host_any_evt) |
                      ((interrupt_request_mode == PPS_INTERRUPT_REQUEST_MODE_BUF3) & host_any_evt &
                       (host_idx == PPS_BUF_LAST)); // RQ15

    // ------------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_commit = (bus_st_reg == PPS_BUS_WAIT);
    wire wr_commit = bus_commit & wb_we_i;
    wire rd_commit = bus_commit & ~wb_we_i;
    wire [7:0] row = wb_adr_i & PPS_BUF_ROW_MASK;
    wire [1:0] sw_idx = wb_adr_i[3:2];
    wire [3:0] sw_sel = one_hot(sw_idx);
    wire hit_pin = (wb_adr_i == PPS_OFF_PIN_EN);
    wire hit_stat = (wb_adr_i == PPS_OFF_STATUS);
    wire hit_cfg = (wb_adr_i == PPS_OFF_CONFIG);
    wire hit_ist = (wb_adr_i == PPS_OFF_INT_ST);
    wire hit_imask = (wb_adr_i == PPS_OFF_INT_MASK);
    wire hit_in = (row == PPS_OFF_IN_BUF) & (wb_adr_i[1:0] == 2'h0);
    wire hit_out = (row == PPS_OFF_OUT_BUF) & (wb_adr_i[1:0] == 2'h0);
    wire sw_in_read = rd_commit & hit_in & slave_mode;
    wire sw_out_write = wr_commit & hit_out & wb_sel_i[0] & slave_mode;
    wire [31:0] wdat_m = merge_bytes(32'h0, wb_dat_i, wb_sel_i);

    wire [31:0] status_word =
        ({31'h0, &in_full_reg} << PPS_IBF_BIT) |      // RQ6
        ({31'h0, ovf_reg} << PPS_INPUT_OVERFLOW_FLAG_BIT) |
        ({28'h0, in_full_reg} << PPS_INPUT_BUFFER_N_FULL_LSB) |
        ({31'h0, &out_empty_reg} << PPS_OBE_BIT) |    // RQ9
        ({31'h0, unf_reg} << PPS_OUTPUT_UNDERFLOW_FLAG_BIT) |
        ({28'h0, out_empty_reg} << PPS_OUTPUT_BUFFER_N_EMPTY_LSB);     // RQ13

    assign mem_bus.host_we = host_store;
    assign mem_bus.host_idx = host_idx;
    assign mem_bus.host_wdata = host_data_i;
    assign mem_bus.sw_we = sw_out_write;
    assign mem_bus.sw_idx = sw_idx;
    assign mem_bus.sw_wdata = wb_dat_i[7:0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        bus_st_next = bus_st_reg;
        case (bus_st_reg)
            PPS_BUS_IDLE: begin
                if (bus_req) begin
                    bus_st_next = PPS_BUS_WAIT;
                end
            end
            PPS_BUS_WAIT: bus_st_next = PPS_BUS_ACK;
            PPS_BUS_ACK: bus_st_next = PPS_BUS_IDLE;
            default: bus_st_next = PPS_BUS_IDLE;
        endcase
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (rd_commit) begin
            // unmapped addresses read zero but are still acknowledged
            rdata_next = 32'h0;
            if (hit_pin) begin
                rdata_next = pin_en_reg;
            end
            if (hit_stat) begin
                rdata_next = status_word;
            end
            if (hit_cfg) begin
                rdata_next = cfg_reg;
            end
            if (hit_ist) begin
                rdata_next = {{(32-PPS_INT_W){1'b0}}, int_st_reg};
            end
            if (hit_imask) begin
                rdata_next = {{(32-PPS_INT_W){1'b0}}, int_mask_reg};
            end
            if (hit_in) begin
                rdata_next = {24'h0, mem_bus.in_rdata};
            end
        end
    end

    assign pin_en_next = (wr_commit & hit_pin)
        ? merge_bytes(pin_en_reg, wb_dat_i, wb_sel_i) & PPS_PIN_EN_MASK
        : pin_en_reg; // RQ13
    assign cfg_next = (wr_commit & hit_cfg)
        ? merge_bytes(cfg_reg, wb_dat_i, wb_sel_i) & PPS_CFG_MASK
        : cfg_reg;
    assign int_mask_next = (wr_commit & hit_imask)
        ? wdat_m[PPS_INT_W-1:0] : int_mask_reg;

    // hardware set beats a software clear in the same cycle
    assign in_full_next = (in_full_reg &
        ~(sw_in_read ? sw_sel : 4'h0)) |
        (host_store ? host_sel : 4'h0); // RQ8
    assign out_empty_next = (out_empty_reg &
        ~(sw_out_write ? sw_sel : 4'h0)) |
        ((host_rd_evt & ~host_hits_empty) ? host_sel : 4'h0); // RQ11
    assign ovf_next = (host_wr_evt & host_hits_full) |
        ((wr_commit & hit_stat & wb_sel_i[1])
            ? wb_dat_i[PPS_INPUT_OVERFLOW_FLAG_BIT] : ovf_reg); // RQ7
    assign unf_next = (host_rd_evt & host_hits_empty) |
        ((wr_commit & hit_stat & wb_sel_i[0])
            ? wb_dat_i[PPS_OUTPUT_UNDERFLOW_FLAG_BIT] : unf_reg); // RQ10
    assign int_st_next = (int_st_reg &
        ~((wr_commit & hit_ist) ? wdat_m[PPS_INT_W-1:0] : '0)) |
        (access_irq ? PPS_INT_ACCESS : '0) |
        ((host_wr_evt & host_hits_full) ? PPS_INT_OVF : '0) |
        ((host_rd_evt & host_hits_empty) ? PPS_INT_UNF : '0);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_reg <= PPS_BUS_IDLE;
            rdata_reg <= 32'h0;
            pin_en_reg <= 32'h0;
            cfg_reg <= 32'h0;
            int_mask_reg <= '0;
            int_st_reg <= '0;
        end else begin
            bus_st_reg <= bus_st_next;
            rdata_reg <= rdata_next;
            pin_en_reg <= pin_en_next;
            cfg_reg <= cfg_next;
            int_mask_reg <= int_mask_next;
            int_st_reg <= int_st_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_full_reg <= 4'h0;
            out_empty_reg <= PPS_OUT_EMPTY_RST;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end else begin
            in_full_reg <= in_full_next;
            out_empty_reg <= out_empty_next;
            ovf_reg <= ovf_next;
            unf_reg <= unf_next;
        end
    end

    // ------------------------------------------------------------------
    // host data path
    // ------------------------------------------------------------------
    // read data leaves the memory one cycle after the strobe edge
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            host_rd_prev_reg <= 1'b0;
            host_wr_prev_reg <= 1'b0;
            host_rd_evt_d_reg <= 1'b0;
            host_data_reg <= 8'h0;
            host_oe_reg <= 1'b0;
        end else begin
            host_rd_prev_reg <= host_rd_lvl;
            host_wr_prev_reg <= host_wr_lvl;
            host_rd_evt_d_reg <= host_rd_evt;
            if (host_rd_evt_d_reg) begin
                host_data_reg <= mem_bus.out_rdata;
            end
            host_oe_reg <= host_rd_lvl & slave_mode;
        end
    end

    // ------------------------------------------------------------------
    // pad function and interrupt outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pad_en_reg <= 16'h0;
            pad_cs_reg <= 1'b0;
            pad_latch_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            pad_en_reg <= pin_en_reg[15:0]; // RQ1 RQ2 RQ3
            pad_cs_reg <= pin_en_reg[PPS_LINE14_BIT] &
                          (chip_select_function == PPS_CSF_CS1); // RQ4 RQ16
            pad_latch_reg <= (|pin_en_reg[1:0]) &
                             (adr_mux != PPS_MUX_NONE); // RQ5
            irq_reg <= |(int_st_reg & int_mask_reg);
        end
    end

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = (bus_st_reg == PPS_BUS_ACK);
    assign host_data_o = host_data_reg;
    assign host_data_oe_o = host_oe_reg;
    assign pad_port_en_o = pad_en_reg;
    assign pad_line14_cs_o = pad_cs_reg;
    assign pad_low_latch_o = pad_latch_reg;
    assign irq_o = irq_reg;
endmodule // pps_top
`default_nettype wire

/* File: rtl/pps_pkg.sv */
// shared constants for the parallel port pin and slave status block
package pps_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PPS_OFF_PIN_EN = 8'h00;
    localparam logic [7:0] PPS_OFF_STATUS = 8'h04;
    localparam logic [7:0] PPS_OFF_CONFIG = 8'h08;
    localparam logic [7:0] PPS_OFF_INT_ST = 8'h0c;
    localparam logic [7:0] PPS_OFF_INT_MASK = 8'h10;
    localparam logic [7:0] PPS_OFF_IN_BUF = 8'h20;
    localparam logic [7:0] PPS_OFF_OUT_BUF = 8'h30;
    localparam logic [7:0] PPS_BUF_ROW_MASK = 8'hf0;
    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] PPS_PIN_EN_MASK = 32'h0000_47ff;
    localparam int PPS_LINE14_BIT = 14;
    localparam int PPS_IBF_BIT = 15;
    localparam int PPS_INPUT_OVERFLOW_FLAG_BIT = 14;
    localparam int PPS_INPUT_BUFFER_N_FULL_LSB = 8;
    localparam int PPS_OBE_BIT = 7;
    localparam int PPS_OUTPUT_UNDERFLOW_FLAG_BIT = 6;
    localparam int PPS_OUTPUT_BUFFER_N_EMPTY_LSB = 0;
    localparam logic [3:0] PPS_OUT_EMPTY_RST = 4'hf;
    localparam int PPS_CFG_MODE_LSB = 0;
    localparam int PPS_CFG_INTERRUPT_REQUEST_MODE_LSB = 2;
    localparam int PPS_CFG_CSF_LSB = 4;
    localparam int PPS_CFG_MUX_LSB = 6;
    localparam logic [31:0] PPS_CFG_MASK = 32'h0000_00ff;
    localparam int PPS_INT_W = 3;
    localparam logic [2:0] PPS_INT_ACCESS = 3'h1;
    localparam logic [2:0] PPS_INT_OVF = 3'h2;
    localparam logic [2:0] PPS_INT_UNF = 3'h4;
    // ------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PPS_MODE_LEGACY = 2'h0;
    localparam logic [1:0] PPS_MODE_ADDR_SLAVE = 2'h1;
    localparam logic [1:0] PPS_MODE_MASTER2 = 2'h2;
    localparam logic [1:0] PPS_MODE_MASTER1 = 2'h3;
    localparam logic [1:0] PPS_INTERRUPT_REQUEST_MODE_END = 2'h1;
    localparam logic [1:0] PPS_INTERRUPT_REQUEST_MODE_BUF3 = 2'h2;
    localparam logic [1:0] PPS_CSF_CS1 = 2'h2;
    localparam logic [1:0] PPS_MUX_NONE = 2'h0;
    localparam logic [1:0] PPS_BUF_LAST = 2'h3;
    localparam logic [1:0] PPS_BUF_FIRST = 2'h0;

    typedef enum logic [2:0] {
        PPS_BUS_IDLE = 3'b001,
        PPS_BUS_WAIT = 3'b010,
        PPS_BUS_ACK = 3'b100
    } pps_bus_state_t;
endpackage

/* File: rtl/pps_mem_if.sv */
// carrier between the port control logic and its byte buffer memory
`timescale 1ns/1ps
`default_nettype none
interface pps_mem_if;
    logic host_we;
    logic [1:0] host_idx;
    logic [7:0] host_wdata;
    logic sw_we;
    logic [1:0] sw_idx;
    logic [7:0] sw_wdata;
    logic [7:0] in_rdata;
    logic [7:0] out_rdata;
    modport ctrl (output host_we, host_idx, host_wdata, sw_we, sw_idx,
                  sw_wdata, input in_rdata, out_rdata);
    modport mem (input host_we, host_idx, host_wdata, sw_we, sw_idx,
                 sw_wdata, output in_rdata, out_rdata);
endinterface
`default_nettype wire

/* File: rtl/pps_buf_mem.sv */
// four input and four output byte buffers with registered read data
`timescale 1ns/1ps
`default_nettype none
module pps_buf_mem
    import pps_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    pps_mem_if.mem bus          // buffer access port
);
    logic [7:0] in_mem [4];
    logic [7:0] out_mem [4];

    // host fills input bytes, software fills output bytes
    always_ff @(posedge sys_clk_i) begin
        if (bus.host_we) begin
            in_mem[bus.host_idx] <= bus.host_wdata;
        end
        if (bus.sw_we) begin
            out_mem[bus.sw_idx] <= bus.sw_wdata;
        end
        bus.in_rdata <= in_mem[bus.sw_idx];
        bus.out_rdata <= out_mem[bus.host_idx];
    end
endmodule // pps_buf_mem
`default_nettype wire

/* File: dv/pps_top_asserts.sv */
// port assertions for the parallel port pin and status block
`timescale 1ns/1ps
`default_nettype none
module pps_top_asserts (
    input wire logic sys_clk_i, // clock
    input wire logic reset_n_i, // raw reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic wb_ack_o, // bus ack
    input wire logic host_cs_i, // host select
    input wire logic host_rd_i, // host read
    input wire logic [7:0] host_data_o, // host byte out
    input wire logic host_data_oe_o, // host drive
    input wire logic [15:0] pad_port_en_o, // pad enables
    input wire logic pad_line14_cs_o, // line 14 as cs
    input wire logic pad_low_latch_o // low pads as latch
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic wr_req;
    logic host_rd;
    assign wr_req = wb_cyc_i && wb_we_i;
    assign host_rd = host_cs_i && host_rd_i;

    property p_ack_lat; $rose(wb_stb_i) |-> ##[1:3] wb_ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("no ack");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_line14; pad_line14_cs_o |-> pad_port_en_o[14]; endproperty
    a_line14: assert property (p_line14) else $error("cs pad off");
    property p_latch;
        pad_low_latch_o |-> (pad_port_en_o[1:0] != 2'h0);
    endproperty
    a_latch: assert property (p_latch) else $error("latch pads off");
    property p_pad_rsv; (pad_port_en_o & 16'hb800) == 16'h0; endproperty
    a_pad_rsv: assert property (p_pad_rsv) else $error("pad rsv");
    property p_pad_chg; !$stable(pad_port_en_o) |-> $past(wr_req); endproperty
    a_pad_chg: assert property (p_pad_chg) else $error("pad moved");
    property p_cs_chg;
        !$stable({pad_line14_cs_o, pad_low_latch_o}) |-> $past(wr_req);
    endproperty
    a_cs_chg: assert property (p_cs_chg) else $error("pad use moved");
    property p_oe; host_data_oe_o |-> $past(host_rd); endproperty
    a_oe: assert property (p_oe) else $error("drive without read");
    property p_dat; !$stable(host_data_o) |-> $past(host_rd, 2); endproperty
    a_dat: assert property (p_dat) else $error("byte moved");
endmodule // pps_top_asserts

bind pps_top pps_top_asserts u_asserts (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .host_cs_i(host_cs_i), .host_rd_i(host_rd_i),
    .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
    .pad_port_en_o(pad_port_en_o), .pad_line14_cs_o(pad_line14_cs_o),
    .pad_low_latch_o(pad_low_latch_o)
);
`default_nettype wire

/* File: dv/pps_host_model.sv */
// external host processor strobing the slave byte buffers
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
    input wire logic clk_i, // clock
    input wire logic [7:0] rdata_i, // device byte
    input wire logic oe_i, // device drives
    output logic cs_o, // chip select
    output logic rd_o, // read strobe
    output logic wr_o, // write strobe
    output logic [1:0] addr_o, // buffer select
    output logic [7:0] data_o // write byte
);
    initial begin
        cs_o = 1'b0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 2'h0;
        data_o = 8'h00;
    end
    // no check for a full buffer: the host may overrun it
    task automatic hw(input logic [1:0] idx, input logic [7:0] d);
        cs_o <= 1'b1;
        wr_o <= 1'b1;
        addr_o <= idx;
        data_o <= d;
        repeat (2) @(posedge clk_i);
        cs_o <= 1'b0;
        wr_o <= 1'b0;
        data_o <= ~d; // released bus must not look valid
        repeat (2) @(posedge clk_i);
    endtask
    // reads empty buffers too, as a careless host would
    task automatic hr(input logic [1:0] idx, output logic [7:0] d,
                      output logic oe);
        cs_o <= 1'b1;
        rd_o <= 1'b1;
        addr_o <= idx;
        repeat (4) @(posedge clk_i);
        d = rdata_i;
        oe = oe_i;
        cs_o <= 1'b0;
        rd_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule // pps_host_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the parallel port pin and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import pps_pkg::*;
    logic sys_clk_i, reset_n_i, cyc, stb, we, ack, hcs, hrd, hwr;
    logic oe, hoe, irq, lcs, llat;
    logic [1:0] hadr;
    logic [7:0] adr, hdi, hdo, b;
    logic [31:0] wdat, rdat, rdq;
    logic [3:0] sel;
    logic [15:0] pen;
    int failures, num_checks, i;

    pps_top dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .host_cs_i(hcs), .host_rd_i(hrd), .host_wr_i(hwr),
        .host_addr_i(hadr), .host_data_i(hdi), .host_data_o(hdo),
        .host_data_oe_o(hoe), .pad_port_en_o(pen),
        .pad_line14_cs_o(lcs), .pad_low_latch_o(llat), .irq_o(irq)
    );
    pps_host_model hm (
        .clk_i(sys_clk_i), .rdata_i(hdo), .oe_i(hoe), .cs_o(hcs),
        .rd_o(hrd), .wr_o(hwr), .addr_o(hadr), .data_o(hdi)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdq = rdat;
        if (n >= 50) begin
            `CHK(ack, 1'b1)
            report_and_stop();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdq, e)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        failures = 0;
        num_checks = 0;
        reset_n_i = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'hf;
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd(PPS_OFF_PIN_EN, 32'h0);
        rd(PPS_OFF_STATUS, 32'h8f);
        rd(8'h44, 32'h0);
        $display("test reset done");
        wr(PPS_OFF_PIN_EN, 32'hffff_ffff);
        rd(PPS_OFF_PIN_EN, 32'h47ff);
        wr(PPS_OFF_CONFIG, 32'h69);
        `CHK(pen, 16'h47ff)
        `CHK({lcs, llat}, 2'b11)
        wr(PPS_OFF_CONFIG, 32'h19);
        `CHK({lcs, llat}, 2'b00)
        wr(PPS_OFF_CONFIG, 32'h69);
        wr(PPS_OFF_PIN_EN, 32'h0);
        `CHK({lcs, llat, pen}, 18'h0)
        $display("test pins done");
        for (i = 0; i < 4; i++) begin
            hm.hw(i[1:0], 8'h10 + i[7:0]);
            rd(PPS_OFF_STATUS, 32'h8f | ((32'h2 << i) - 32'h1) << 8 |
               (i == 3 ? 32'h8000 : 32'h0));
        end
        hm.hw(2'h0, 8'hee);
        rd(PPS_OFF_STATUS, 32'hcf8f);
        rd(PPS_OFF_IN_BUF, 32'h10);
        rd(PPS_OFF_STATUS, 32'h4e8f);
        // lane 0 only: the overflow flag in lane 1 must survive
        sel <= 4'h1;
        wr(PPS_OFF_STATUS, 32'h0);
        rd(PPS_OFF_STATUS, 32'h4e8f);
        sel <= 4'hf;
        wr(PPS_OFF_STATUS, 32'h0);
        rd(PPS_OFF_STATUS, 32'h0e8f);
        for (i = 1; i < 4; i++) begin
            rd(PPS_OFF_IN_BUF + 8'(4 * i), 32'h10 + i);
        end
        rd(PPS_OFF_STATUS, 32'h8f);
        $display("test input buffers done");
        wr(PPS_OFF_OUT_BUF + 8'h4, 32'h5a);
        rd(PPS_OFF_STATUS, 32'hd);
        hm.hr(2'h1, b, oe);
        `CHK({oe, b}, 9'h15a)
        rd(PPS_OFF_STATUS, 32'h8f);
        hm.hr(2'h2, b, oe);
        rd(PPS_OFF_STATUS, 32'hcf);
        wr(PPS_OFF_STATUS, 32'h0);
        rd(PPS_OFF_STATUS, 32'h8f);
        $display("test output buffers done");
        rd(PPS_OFF_INT_ST, 32'h7);
        `CHK(irq, 1'b0)
        wr(PPS_OFF_INT_MASK, 32'h7);
        `CHK(irq, 1'b1)
        wr(PPS_OFF_INT_ST, 32'h7);
        rd(PPS_OFF_INT_ST, 32'h0);
        `CHK(irq, 1'b0)
        $display("test interrupt done");
        wr(PPS_OFF_CONFIG, 32'h68);
        hm.hw(2'h3, 8'h3c);
        xfer(1'b0, PPS_OFF_STATUS, 32'h0);
        `CHK(rdq[11:8], 4'h1)
        rd(PPS_OFF_IN_BUF, 32'h3c);
        for (i = 2; i < 4; i++) begin
            wr(PPS_OFF_CONFIG, 32'h68 | i);
            hm.hw(2'h0, 8'h77);
            rd(PPS_OFF_STATUS, 32'h8f);
        end
        // end-of-cycle interrupt mode fires on any buffer
        wr(PPS_OFF_CONFIG, 32'h5);
        hm.hw(2'h1, 8'h01);
        rd(PPS_OFF_STATUS, 32'h28f);
        rd(PPS_OFF_INT_ST, 32'h1);
        `CHK(irq, 1'b1)
        $display("test modes done");
        report_and_stop();
    end

    // any run still going after 20000 cycles ends here; a hung bus handshake ends in xfer
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
